// File: hdl/steal_ctrl_pkg.sv
// shared constants and command encodings for the cycle-steal control block
package steal_ctrl_pkg;
  localparam int          NUM_CTR_KINDS = 7;        // pinc, minc, pcdu, mcdu, shinc, shanc, dinc
  localparam int          CTR_W         = 7;        // width of the counter instruction vector
  localparam logic [2:0]  STAGE_ZERO    = 3'h0;     // first memory cycle of store/fetch
  localparam logic [2:0]  STAGE_ONE     = 3'h1;     // second memory cycle of store/fetch
  localparam logic        FLOP_RESET    = 1'b0;     // every flop clears on reset
  localparam logic [6:0]  CTR_CLEAR     = 7'h00;    // counter instruction flops after reset
  // index of each counter instruction flop
  localparam int          CI_PINC       = 0;
  localparam int          CI_MINC       = 1;
  localparam int          CI_PCDU       = 2;
  localparam int          CI_MCDU       = 3;
  localparam int          CI_SHINC      = 4;
  localparam int          CI_SHANC      = 5;
  localparam int          CI_DINC       = 6;
endpackage

// File: hdl/steal_timing_if.sv
// timing qualifiers passed from the top to the counter instruction latch
`timescale 1ns/1ps
interface steal_timing_if;
  logic clk_en;        // enable slot, true on the latch strobe or the end pulse
  logic latch_strobe;  // counter-latch strobe
  logic end_pulse;     // time pulse twelve, ends counter instructions
  modport ctrl (output clk_en, output latch_strobe, output end_pulse);
  modport latch (input clk_en, input latch_strobe, input end_pulse);
endinterface

// File: hdl/counter_instr_latch.sv
// counter instruction flip-flops set by the latch strobe and cleared at time pulse twelve
`timescale 1ns/1ps
module counter_instr_latch
  import steal_ctrl_pkg::*;
#(
  parameter int W = CTR_W
)
(
  input  wire logic         clk,
  input  wire logic         reset,
  steal_timing_if.latch     tim,
  input  wire logic [W-1:0] req,
  output logic      [W-1:0] instr
);
  logic [W-1:0] instr_reg;   // one flop per counter instruction kind
  logic [W-1:0] instr_next;  // next state

  // a request only sets its flop on the strobe; flops hold from pulse two to pulse twelve
  assign instr_next = tim.latch_strobe ? (instr_reg | req)   // [RULE_11]
                    : (tim.end_pulse ? {W{1'b0}} : instr_reg);

  // plain synchronous update
  always_ff @(posedge clk)
  begin
    if (reset)
      instr_reg <= {W{1'b0}};
    else if (tim.clk_en)
      instr_reg <= instr_next;
  end

  assign instr = instr_reg;
endmodule

// File: hdl/counter_peripheral_instr_ctrl.sv
// cycle-steal control for counter increments and peripheral memory instructions
`timescale 1ns/1ps
// Behaviour
// RULE_01 - hold freezes decoding before steal instructions
// RULE_02 - jam blocks steals until next pulse one
// RULE_03 - window only pulse twelve phase four, end flag
// RULE_04 - counter cycle set by window and requests
// RULE_05 - peripheral request blocks counter cycle set
// RULE_06 - jam wins over counter cycle set
// RULE_07 - counter cycle ends twelve phase three if peripheral
// RULE_08 - counter cycle ends pulse twelve without requests
// RULE_09 - hold is counter cycle or peripheral active
// RULE_10 - latch at pulse two, cell reset pulse seven
// RULE_11 - latch strobe sets matching counter instruction flop
// RULE_12 - cell reset strobe clears serviced cell
// RULE_13 - copy of hold sent outside
// RULE_14 - peripheral request set phase two, cleared pulse eleven
// RULE_15 - channel load one cycle, ends twelve phase two
// RULE_16 - channel read same timing as load
// RULE_17 - channel flops make increment and active
// RULE_18 - store set without jam, two cycles
// RULE_19 - stage zero first fetch, stage one second
// RULE_20 - fetch cleared twelve phase two stage one
// RULE_21 - store cleared twelve phase two stage one
// RULE_22 - combined second stage store or fetch
// RULE_23 - acknowledge accepted request to equipment
// RULE_24 - all flops on one clock with enables
module counter_peripheral_instr_ctrl
(
  input  wire logic                                CLK,
  input  wire logic                                RESET,
  input  wire logic                                GLOBAL_JAM_RESET,
  input  wire logic                                ANY_COUNTER_REQUEST,
  input  wire logic [steal_ctrl_pkg::CTR_W-1:0]    COUNTER_KIND_REQUEST,
  input  wire logic                                EXT_FETCH_REQUEST,
  input  wire logic                                EXT_STORE_REQUEST,
  input  wire logic                                EXT_CHANNEL_READ_REQUEST,
  input  wire logic                                EXT_CHANNEL_LOAD_REQUEST,
  input  wire logic                                MANUAL_INCREMENT_INHIBIT,
  input  wire logic                                END_OF_INSTRUCTION_FLAG,
  input  wire logic                                TIME_PULSE_ONE,
  input  wire logic                                TIME_PULSE_TWO,
  input  wire logic                                TIME_PULSE_SEVEN,
  input  wire logic                                TIME_PULSE_ELEVEN,
  input  wire logic                                TIME_PULSE_TWELVE,
  input  wire logic                                QUARTER_PHASE_TWO,
  input  wire logic                                QUARTER_PHASE_THREE,
  input  wire logic                                QUARTER_PHASE_FOUR,
  input  wire logic [2:0]                          STAGE_COUNT,
  output logic                                     CYCLE_STEAL_HOLD,
  output logic                                     DECODE_ENABLE,
  output logic                                     EXTERNAL_HOLD_COPY,
  output logic                                     REQUEST_ACCEPTED_ACK,
  output logic                                     COUNTER_LATCH_STROBE,
  output logic                                     CELL_RESET_STROBE,
  output logic [steal_ctrl_pkg::CTR_W-1:0]         COUNTER_INSTR,
  output logic                                     CHANNEL_LOAD_FLOP,
  output logic                                     CHANNEL_READ_FLOP,
  output logic                                     CHANNEL_INCREMENT_CMD,
  output logic                                     PERIPHERAL_ACTIVE,
  output logic                                     MEMORY_ACCESS_ACTIVE,
  output logic                                     FIRST_FETCH_CMD,
  output logic                                     STORE_STAGE_TWO_CMD,
  output logic                                     FETCH_STAGE_TWO_CMD,
  output logic                                     STORE_OR_FETCH_STAGE_TWO
);
  import steal_ctrl_pkg::*;

  // stage code compare, shared by the first and the second memory cycle
  function automatic logic stage_is
  (
    input logic [2:0] code,
    input logic [2:0] want
  );
    stage_is = (code == want);
  endfunction

  // a time pulse qualified by one of its quarter phases
  function automatic logic slot_is
  (
    input logic pulse,
    input logic phase
  );
    slot_is = pulse & phase;
  endfunction

  // two-flop synchronisers for the external equipment request lines;
  // the equipment keeps its own timing, so a bare line could go metastable
  // and two flops cost two cycles of latency, far inside one memory cycle
  logic [3:0] ext_meta_reg;     // first stage, read only by second stage
  logic [3:0] ext_sync_reg;     // second stage, usable by logic
  logic       inhibit_meta_reg; // manual inhibit first stage
  logic       inhibit_sync_reg; // manual inhibit second stage

  // control flops
  logic jam_inhibit_flop_reg;   // jam holds off steals until next pulse one
  logic periph_req_reg;         // peripheral request pending
  logic counter_cycle_reg;      // counter increment cycle in progress
  logic chan_load_reg;          // channel load subinstruction
  logic chan_read_reg;          // channel read subinstruction
  logic store_reg;              // memory store instruction
  logic fetch_reg;              // memory fetch instruction

  // next values, one per control flop
  logic jam_inhibit_flop_next;  // jam inhibit next
  logic periph_req_next;        // peripheral request next
  logic counter_cycle_next;     // counter cycle next
  logic chan_load_next;         // channel load next
  logic chan_read_next;         // channel read next
  logic store_next;             // store next
  logic fetch_next;             // fetch next

  // decoded conditions
  wire       jam        = GLOBAL_JAM_RESET;  // same clock, so no synchroniser
  wire       sync_fetch = ext_sync_reg[0];   // fetch line after sync
  wire       sync_store = ext_sync_reg[1];   // store line after sync
  wire       sync_read  = ext_sync_reg[2];   // channel read line after sync
  wire       sync_load  = ext_sync_reg[3];   // channel load line after sync
  wire       any_ext    = |ext_sync_reg;     // any equipment line up
  // quarters of the last time pulse that open and close instructions, and the pulse seven cell reset slot
  wire       end_q2     = slot_is(TIME_PULSE_TWELVE, QUARTER_PHASE_TWO);
  wire       end_q3     = slot_is(TIME_PULSE_TWELVE, QUARTER_PHASE_THREE);
  wire       end_q4     = slot_is(TIME_PULSE_TWELVE, QUARTER_PHASE_FOUR);
  wire       cell_slot  = slot_is(TIME_PULSE_SEVEN, QUARTER_PHASE_THREE);
  // stage code seen by the store and fetch commands
  wire       in_stage0  = stage_is(STAGE_COUNT, STAGE_ZERO);
  wire       in_stage1  = stage_is(STAGE_COUNT, STAGE_ONE);
  wire       mem_active;     // store or fetch running
  wire       periph_active;  // any peripheral instruction running
  wire       window_strobe;  // the one slot in which a steal may start
  wire       counter_set;    // conditions that start a counter cycle
  wire       counter_end;    // conditions that end a counter cycle
  wire       mem_end;        // end of the second store or fetch cycle
  wire       hold;           // freeze of the order-code decoding

  // timing qualifiers carried to the counter instruction latch
  steal_timing_if tim ();

  // synchronise the asynchronous lines from the outside equipment
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ext_meta_reg     <= {4{FLOP_RESET}};
      ext_sync_reg     <= {4{FLOP_RESET}};
      inhibit_meta_reg <= FLOP_RESET;
      inhibit_sync_reg <= FLOP_RESET;
    end
    else
    begin
      ext_meta_reg     <= {EXT_CHANNEL_LOAD_REQUEST, EXT_CHANNEL_READ_REQUEST,
                           EXT_STORE_REQUEST, EXT_FETCH_REQUEST};
      ext_sync_reg     <= ext_meta_reg;
      inhibit_meta_reg <= MANUAL_INCREMENT_INHIBIT;
      inhibit_sync_reg <= inhibit_meta_reg;
    end
  end

  // window opens only at end of instruction, last quarter of pulse twelve;
  // without the end flag a steal would split a program instruction
  assign window_strobe = end_q4                                      // [RULE_03]
                       & END_OF_INSTRUCTION_FLAG
                       & ~jam_inhibit_flop_reg & ~jam;               // [RULE_02]

  // memory instructions and channel subinstructions mark peripheral activity
  assign mem_active    = store_reg | fetch_reg;
  assign periph_active = mem_active | chan_load_reg | chan_read_reg; // [RULE_17]

  // hold is what freezes the order-code and stage decoders;
  // the stored order code itself is untouched and decoded afterwards
  assign hold = counter_cycle_reg | periph_active;                   // [RULE_09]

  // jam inhibit: set by jam away from pulse one, cleared at next pulse one
  assign jam_inhibit_flop_next = (jam & ~TIME_PULSE_ONE)             // [RULE_02]
                               | (jam_inhibit_flop_reg & ~TIME_PULSE_ONE);

  // peripheral request: caught at phase two, dropped at pulse eleven once
  // active; a new line at phase two wins over the drop in the same cycle
  assign periph_req_next = jam ? 1'b0                                // [RULE_14]
                         : ((any_ext & QUARTER_PHASE_TWO)
                            | (periph_req_reg & ~(TIME_PULSE_ELEVEN & periph_active)));

  // counter cycle start: peripheral requests go first
  assign counter_set = window_strobe & ANY_COUNTER_REQUEST
                     & ~inhibit_sync_reg                             // [RULE_04]
                     & ~periph_req_reg;                              // [RULE_05]

  // counter cycle end: yield to a peripheral, or nothing left to count
  assign counter_end = (end_q3 & periph_req_reg)                     // [RULE_07]
                     | (TIME_PULSE_TWELVE & ~ANY_COUNTER_REQUEST);   // [RULE_08]

  // jam overrides a start that falls in the same cycle
  assign counter_cycle_next = jam ? 1'b0                             // [RULE_06]
                            : counter_set | (counter_cycle_reg & ~counter_end);

  // channel subinstructions last one memory cycle
  assign chan_load_next = jam ? 1'b0
                        : (sync_load & periph_req_reg & window_strobe)  // [RULE_15]
                        | (chan_load_reg & ~end_q2);
  assign chan_read_next = jam ? 1'b0
                        : (sync_read & periph_req_reg & window_strobe)  // [RULE_16]
                        | (chan_read_reg & ~end_q2);

  // store and fetch span two cycles, ending at phase two of stage one;
  // the stage code is checked so the first cycle's pulse twelve passes
  assign mem_end    = end_q2 & mem_active & in_stage1;                // [RULE_20] [RULE_21]
  assign store_next = jam ? 1'b0                                        // [RULE_18]
                    : (sync_store & periph_req_reg & window_strobe)
                    | (store_reg & ~mem_end);                           // [RULE_21]
  assign fetch_next = jam ? 1'b0
                    : (sync_fetch & periph_req_reg & window_strobe)     // [RULE_20]
                    | (fetch_reg & ~mem_end);

  // all flops share the one clock; time pulses act only as enables
  always_ff @(posedge CLK)                                             // [RULE_24]
  begin
    if (RESET)
    begin
      jam_inhibit_flop_reg <= FLOP_RESET;
      periph_req_reg       <= FLOP_RESET;
      counter_cycle_reg    <= FLOP_RESET;
      chan_load_reg        <= FLOP_RESET;
      chan_read_reg        <= FLOP_RESET;
      store_reg            <= FLOP_RESET;
      fetch_reg            <= FLOP_RESET;
    end
    else
    begin
      jam_inhibit_flop_reg <= jam_inhibit_flop_next;
      periph_req_reg       <= periph_req_next;
      counter_cycle_reg    <= counter_cycle_next;
      chan_load_reg        <= chan_load_next;
      chan_read_reg        <= chan_read_next;
      store_reg            <= store_next;
      fetch_reg            <= fetch_next;
    end
  end

  // strobes toward the priority cells, only during a counter cycle
  assign tim.latch_strobe = TIME_PULSE_TWO & counter_cycle_reg;        // [RULE_10]
  assign tim.end_pulse    = TIME_PULSE_TWELVE;
  // the latch only moves on its strobe or at the end pulse
  assign tim.clk_en       = tim.latch_strobe | tim.end_pulse;

  // counter instruction flops live in their own small module
  counter_instr_latch #(
    .W     (CTR_W)
  ) u_latch (
    .clk   (CLK),
    .reset (RESET),
    .tim   (tim),
    .req   (COUNTER_KIND_REQUEST),                                     // [RULE_11]
    .instr (COUNTER_INSTR)
  );

  // handshake and command outputs
  assign CYCLE_STEAL_HOLD         = hold;                               // [RULE_01]
  assign DECODE_ENABLE            = ~hold;                              // [RULE_01]
  // the equipment may stop at pulse twelve on this copy
  assign EXTERNAL_HOLD_COPY       = hold;                               // [RULE_13]
  // accepted request; the equipment must hold its request lines until the window starts the instruction
  assign REQUEST_ACCEPTED_ACK     = periph_req_reg;                     // [RULE_23]
  assign COUNTER_LATCH_STROBE     = tim.latch_strobe;                   // [RULE_10]
  // cell reset strobe, combined with the counter address outside
  assign CELL_RESET_STROBE        = cell_slot & counter_cycle_reg;      // [RULE_10] [RULE_12]
  // channel subinstruction commands
  assign CHANNEL_LOAD_FLOP        = chan_load_reg;                      // [RULE_15]
  assign CHANNEL_READ_FLOP        = chan_read_reg;                      // [RULE_16]
  assign CHANNEL_INCREMENT_CMD    = chan_load_reg | chan_read_reg;      // [RULE_17]
  assign PERIPHERAL_ACTIVE        = periph_active;                      // [RULE_17]
  // store and fetch commands, split by stage code
  assign MEMORY_ACCESS_ACTIVE     = mem_active;
  assign FIRST_FETCH_CMD          = mem_active & in_stage0;             // [RULE_19]
  assign STORE_STAGE_TWO_CMD      = store_reg & in_stage1;              // [RULE_19]
  assign FETCH_STAGE_TWO_CMD      = fetch_reg & in_stage1;              // [RULE_19]
  assign STORE_OR_FETCH_STAGE_TWO = mem_active & in_stage1;             // [RULE_22]
endmodule

// File: dv/steal_ctrl_assertions.sv
// concurrent checks on the cycle-steal control ports
`timescale 1ns/1ps
module steal_ctrl_assertions
(
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       GLOBAL_JAM_RESET,
  input wire logic       END_OF_INSTRUCTION_FLAG,
  input wire logic       TIME_PULSE_TWO,
  input wire logic       TIME_PULSE_SEVEN,
  input wire logic       TIME_PULSE_TWELVE,
  input wire logic       QUARTER_PHASE_TWO,
  input wire logic       QUARTER_PHASE_THREE,
  input wire logic       QUARTER_PHASE_FOUR,
  input wire logic [2:0] STAGE_COUNT,
  input wire logic       CYCLE_STEAL_HOLD,
  input wire logic       DECODE_ENABLE,
  input wire logic       EXTERNAL_HOLD_COPY,
  input wire logic       REQUEST_ACCEPTED_ACK,
  input wire logic       COUNTER_LATCH_STROBE,
  input wire logic       CELL_RESET_STROBE,
  input wire logic       CHANNEL_LOAD_FLOP,
  input wire logic       CHANNEL_READ_FLOP,
  input wire logic       CHANNEL_INCREMENT_CMD,
  input wire logic       PERIPHERAL_ACTIVE,
  input wire logic       MEMORY_ACCESS_ACTIVE,
  input wire logic       FIRST_FETCH_CMD,
  input wire logic       STORE_STAGE_TWO_CMD,
  input wire logic       FETCH_STAGE_TWO_CMD,
  input wire logic       STORE_OR_FETCH_STAGE_TWO
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  hold_copy_a: assert property (EXTERNAL_HOLD_COPY == CYCLE_STEAL_HOLD
    && DECODE_ENABLE == !CYCLE_STEAL_HOLD) else $error("hold copy or decode gate wrong");
  hold_start_a: assert property ($rose(CYCLE_STEAL_HOLD) |-> $past(TIME_PULSE_TWELVE
    && QUARTER_PHASE_FOUR && END_OF_INSTRUCTION_FLAG)) else $error("steal outside window");
  latch_time_a: assert property (COUNTER_LATCH_STROBE |-> TIME_PULSE_TWO
    && CYCLE_STEAL_HOLD && !PERIPHERAL_ACTIVE) else $error("latch strobe mistimed");
  cell_time_a: assert property (CELL_RESET_STROBE |-> TIME_PULSE_SEVEN
    && QUARTER_PHASE_THREE && CYCLE_STEAL_HOLD) else $error("cell reset mistimed");
  jam_clear_a: assert property (GLOBAL_JAM_RESET |=> !CYCLE_STEAL_HOLD)
    else $error("hold survived jam");
  chan_end_a: assert property ($fell(CHANNEL_LOAD_FLOP) |-> $past(RESET) ||
    $past(TIME_PULSE_TWELVE && QUARTER_PHASE_TWO || GLOBAL_JAM_RESET)) else $error("load end");
  chan_cmd_a: assert property (CHANNEL_INCREMENT_CMD ==
    (CHANNEL_LOAD_FLOP || CHANNEL_READ_FLOP)
    && PERIPHERAL_ACTIVE == (CHANNEL_INCREMENT_CMD || MEMORY_ACCESS_ACTIVE)) else $error("chan");
  active_hold_a: assert property (PERIPHERAL_ACTIVE |-> CYCLE_STEAL_HOLD)
    else $error("peripheral without hold");
  stage_cmd_a: assert property (FIRST_FETCH_CMD ==
    (MEMORY_ACCESS_ACTIVE && STAGE_COUNT == 3'h0)
    && STORE_OR_FETCH_STAGE_TWO == (STORE_STAGE_TWO_CMD || FETCH_STAGE_TWO_CMD))
    else $error("stage");
  ack_rise_a: assert property ($rose(REQUEST_ACCEPTED_ACK) |-> $past(QUARTER_PHASE_TWO))
    else $error("request taken off phase two");
  // main scenarios seen
  cover property ($rose(CYCLE_STEAL_HOLD));
  cover property ($rose(CHANNEL_LOAD_FLOP));
  cover property ($rose(STORE_STAGE_TWO_CMD));
endmodule
bind counter_peripheral_instr_ctrl steal_ctrl_assertions chk (.*);

// File: dv/steal_partner.sv
// priority cells and peripheral equipment facing the steal control
`timescale 1ns/1ps
module steal_partner
  import steal_ctrl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [CTR_W-1:0] cell_set,
  input  wire logic [3:0]       ext_set,
  input  wire logic             cell_reset_strobe,
  input  wire logic             peripheral_active,
  output logic                  any_req,
  output logic      [CTR_W-1:0] kind_req,
  output logic      [3:0]       ext_req
);
  logic [CTR_W-1:0] cells_reg;  // pending counter cells
  logic [3:0]       lines_reg;  // fetch, store, channel read, channel load
  // lowest pending cell is the one whose address is decoded
  wire  [CTR_W-1:0] serviced = cells_reg & (~cells_reg + 1'b1);
  assign any_req  = |cells_reg;
  assign kind_req = serviced;
  assign ext_req  = lines_reg;
  // lines drop once the instruction runs, never before it is taken
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cells_reg <= CTR_CLEAR;
      lines_reg <= 4'h0;
    end
    else
    begin
      cells_reg <= (cells_reg | cell_set) & ~(cell_reset_strobe ? serviced : CTR_CLEAR);
      lines_reg <= peripheral_active ? 4'h0 : (lines_reg | ext_set);
    end
  end
endmodule

// File: dv/counter_peripheral_instr_ctrl_bench.sv
// self-checking bench for the cycle-steal control
`timescale 1ns/1ps
module counter_peripheral_instr_ctrl_bench;
  import steal_ctrl_pkg::*;
  logic CLK, RESET, GLOBAL_JAM_RESET, MANUAL_INCREMENT_INHIBIT, END_OF_INSTRUCTION_FLAG;
  logic ANY_COUNTER_REQUEST, EXT_FETCH_REQUEST, EXT_STORE_REQUEST;
  logic EXT_CHANNEL_READ_REQUEST, EXT_CHANNEL_LOAD_REQUEST, CYCLE_STEAL_HOLD, DECODE_ENABLE;
  logic EXTERNAL_HOLD_COPY, REQUEST_ACCEPTED_ACK, COUNTER_LATCH_STROBE, CELL_RESET_STROBE;
  logic CHANNEL_LOAD_FLOP, CHANNEL_READ_FLOP, CHANNEL_INCREMENT_CMD, PERIPHERAL_ACTIVE;
  logic MEMORY_ACCESS_ACTIVE, FIRST_FETCH_CMD, STORE_STAGE_TWO_CMD, FETCH_STAGE_TWO_CMD;
  logic STORE_OR_FETCH_STAGE_TWO;
  logic [CTR_W-1:0] COUNTER_KIND_REQUEST, COUNTER_INSTR, cell_set;
  logic [2:0]       STAGE_COUNT;
  logic [3:0]       ext_set;
  logic [5:0]       cyc;        // slot in the memory cycle: (time pulse - 1) times four plus (quarter phase - 1), 0 to 47
  int               ticks, fail_count, check_count;
  // time pulses and quarter phases decoded from the slot
  wire TIME_PULSE_ONE = cyc[5:2] == 4'h0;
  wire TIME_PULSE_TWO = cyc[5:2] == 4'h1;
  wire TIME_PULSE_SEVEN = cyc[5:2] == 4'h6;
  wire TIME_PULSE_ELEVEN = cyc[5:2] == 4'hA;
  wire TIME_PULSE_TWELVE = cyc[5:2] == 4'hB;
  wire QUARTER_PHASE_TWO = cyc[1:0] == 2'h1;
  wire QUARTER_PHASE_THREE = cyc[1:0] == 2'h2;
  wire QUARTER_PHASE_FOUR = cyc[1:0] == 2'h3;
  wire [9:0] vec = {REQUEST_ACCEPTED_ACK, CHANNEL_LOAD_FLOP, CHANNEL_READ_FLOP,
    CHANNEL_INCREMENT_CMD, PERIPHERAL_ACTIVE, MEMORY_ACCESS_ACTIVE, FIRST_FETCH_CMD,
    STORE_STAGE_TWO_CMD, FETCH_STAGE_TWO_CMD, STORE_OR_FETCH_STAGE_TWO};
  counter_peripheral_instr_ctrl dut (.*);
  steal_partner far (.clk(CLK), .reset(RESET), .cell_set(cell_set), .ext_set(ext_set),
    .cell_reset_strobe(CELL_RESET_STROBE), .peripheral_active(PERIPHERAL_ACTIVE),
    .any_req(ANY_COUNTER_REQUEST), .kind_req(COUNTER_KIND_REQUEST),
    .ext_req({EXT_CHANNEL_LOAD_REQUEST, EXT_CHANNEL_READ_REQUEST, EXT_STORE_REQUEST,
    EXT_FETCH_REQUEST}));
  always #25 CLK = ~CLK;
  // slot counter, stage counter of the order-code side, and hang guard
  always @(posedge CLK)
  begin
    cyc <= (cyc == 6'h2F) ? 6'h00 : cyc + 1'b1;
    if (!MEMORY_ACCESS_ACTIVE) STAGE_COUNT <= STAGE_ZERO;
    else if (cyc == 6'h2F) STAGE_COUNT <= STAGE_ONE;
    ticks <= ticks + 1;
    if (ticks == 6000)
    begin
      fail_count++;
      close_out;
    end
  end
  task check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait until the given slot, then let that edge's updates land
  task at(input logic [5:0] s);
    repeat (49)
    begin
      @(posedge CLK);
      #1;
      if (cyc === s) break;
    end
  endtask
  // one-cycle request pulse to the far side
  task poke(input logic [CTR_W-1:0] c, input logic [3:0] e);
    @(posedge CLK);
    cell_set <= c;
    ext_set <= e;
    @(posedge CLK);
    cell_set <= CTR_CLEAR;
    ext_set <= 4'h0;
  endtask
  // counter steal of kind k; mode 1..3 first blocks one window
  task ctr_run(input int k, input int mode);
    at(6'h1E);
    @(posedge CLK);
    END_OF_INSTRUCTION_FLAG <= (mode != 1);
    MANUAL_INCREMENT_INHIBIT <= (mode == 2);
    GLOBAL_JAM_RESET <= (mode == 3);
    poke(7'h01 << k, 4'h0);
    GLOBAL_JAM_RESET <= 1'b0;
    if (mode != 0)
    begin
      at(6'h00);
      check({9'h000, CYCLE_STEAL_HOLD}, 10'h000);
      @(posedge CLK);
      END_OF_INSTRUCTION_FLAG <= 1'b1;
      MANUAL_INCREMENT_INHIBIT <= 1'b0;
    end
    at(6'h00);
    check({7'h00, DECODE_ENABLE, EXTERNAL_HOLD_COPY, CYCLE_STEAL_HOLD}, 10'h003);
    at(6'h08);
    check({3'h0, COUNTER_INSTR}, 10'h001 << k);
    at(6'h1E);
    check({9'h000, ANY_COUNTER_REQUEST}, 10'h000);
    at(6'h2E);
    check({CYCLE_STEAL_HOLD, 2'h0, COUNTER_INSTR}, 10'h000);
  endtask
  // peripheral instruction on line idx, first and second memory cycle
  task periph(input int idx, input logic [9:0] c1, input logic [9:0] c2);
    at(6'h1E);
    poke(CTR_CLEAR, 4'h1 << idx);
    at(6'h00);
    check(vec, c1);
    at(6'h00);
    check(vec, c2);
    at(6'h2E);
    check({CYCLE_STEAL_HOLD, vec[8:0]}, 10'h000);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {CLK, GLOBAL_JAM_RESET, MANUAL_INCREMENT_INHIBIT, cyc, STAGE_COUNT, ticks} = '0;
    {fail_count, check_count, cell_set, ext_set} = '0;
    END_OF_INSTRUCTION_FLAG = 1'b1;
    RESET = 1'b1;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    for (int k = 0; k < CTR_W; k++) ctr_run(k, 0);
    $display("counter kinds done");
    for (int m = 1; m < 4; m++) ctr_run(0, m);
    $display("blocked windows done");
    periph(0, 10'h238, 10'h033);
    periph(1, 10'h238, 10'h035);
    periph(2, 10'h2E0, 10'h000);
    periph(3, 10'h360, 10'h000);
    $display("peripheral instructions done");
    // peripheral arrives during a counter cycle with a second cell waiting
    at(6'h1E);
    poke(7'h03, 4'h0);
    at(6'h0A);
    poke(CTR_CLEAR, 4'h8);
    at(6'h2F);
    check({9'h000, CYCLE_STEAL_HOLD}, 10'h000);
    at(6'h00);
    check(vec, 10'h360);
    at(6'h08);
    check({3'h0, COUNTER_INSTR}, 10'h000);
    at(6'h00);
    at(6'h08);
    check({3'h0, COUNTER_INSTR}, 10'h002);
    at(6'h2E);
    check({9'h000, CYCLE_STEAL_HOLD}, 10'h000);
    $display("priority done");
    close_out;
  end
endmodule
